/* File: hw/chio_handler_io.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - busy low whole time measurement runs
// - handler outputs active low, released high otherwise; engine pulses and value strobe active high
// - start and stop inputs active low
// - start input begins selected test measurement
// - stop input aborts running measurement
// - line one: pass bin1, sec-only, sequence pass
// - lines two-seven bins or step fails
// - line eleven/twelve secondary low/high fail
// - line thirteen primary fail secondary pass
// - line fourteen both judgments fail
// - end-of-test low after measurement completes
// - low-accuracy no-readout withholds values
module chio_handler_io
  import chio_pkg::*;
(
  input  wire logic                         sys_clk_i,           // system clock, 10 MHz
  input  wire logic                         rst_i,               // synchronous reset, active high
  input  wire logic                         start_n_i,           // handler start, active low
  input  wire logic                         stop_n_i,            // handler stop, active low
  input  wire logic                         low_accuracy_no_readout_i, // no-display accuracy setting
  input  wire logic                         meas_done_i,         // measurement engine finished, pulse
  input  wire logic                         seq_test_i,          // selected test is a sequence test
  input  wire logic                         prim_pass_i,         // primary judgment passed
  input  wire logic [chio_pkg::BIN_W-1:0]   prim_bin_i,          // primary bin 1..10
  input  wire logic                         bin_enable_i,        // binning enabled
  input  wire logic                         prim_limits_off_i,   // all primary bin limits off
  input  wire chio_pkg::chio_sec_t          sec_judge_i,         // secondary judgment
  input  wire logic [chio_pkg::NUM_STEPS-1:0] step_fail_i,       // per-step fail of a sequence
  input  wire logic [31:0]                  meas_value_i,        // measured value from engine
  output logic                              meas_start_o,        // begin measurement, pulse
  output logic                              meas_abort_o,        // abort measurement, pulse
  output logic                              busy_n_o,            // measurement running, active low
  output logic                              test_done_strobe_n_o, // end of test, active low
  output logic [chio_pkg::NUM_SORT-1:0]     sort_n_o,            // sort lines, active low
  output logic                              value_valid_o,       // value released to command ports
  output logic [31:0]                       value_o              // value for command ports
);
  import chio_pkg::*;

  chio_state_t              state_q;      // port sequencing state
  logic                     start_q;      // previous start level
  logic                     stop_q;       // previous stop level
  logic                     start_evt;    // falling edge of start
  logic                     stop_evt;     // falling edge of stop
  logic [NUM_SORT-1:0]      sort_d;       // decoded active-high judgments

  // command edges: a held low level counts once
  assign start_evt = ~start_n_i & start_q;
  assign stop_evt  = ~stop_n_i & stop_q;

  // previous input levels, released means high
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_q <= 1'b1;
      stop_q  <= 1'b1;
    end else begin
      start_q <= start_n_i;
      stop_q  <= stop_n_i;
    end
  end

  // decode judgments into sort lines
  always_comb begin
    sort_d = '0;
    if (seq_test_i) begin
      // sequence: line one all pass, two..seven step fails
      sort_d[0] = ~|step_fail_i;
      sort_d[SORT_STEP0 +: NUM_STEPS] = step_fail_i;
    end else begin
      if (prim_pass_i && prim_bin_i >= BIN_W'(1) && prim_bin_i <= BIN_W'(NUM_PBINS)) begin
        if (sec_judge_i == CHIO_SEC_PASS || sec_judge_i == CHIO_SEC_NONE) begin
          sort_d[prim_bin_i - BIN_W'(1)] = 1'b1;
        end
      end
      // secondary-only binning lands on line one
      if (bin_enable_i && prim_limits_off_i && sec_judge_i == CHIO_SEC_PASS) begin
        sort_d[0] = 1'b1;
      end
      if (prim_pass_i && sec_judge_i == CHIO_SEC_LOW) begin
        sort_d[SORT_SEC_LO] = 1'b1;
      end
      if (prim_pass_i && sec_judge_i == CHIO_SEC_HIGH) begin
        sort_d[SORT_SEC_HI] = 1'b1;
      end
      if (!prim_pass_i && sec_judge_i == CHIO_SEC_PASS) begin
        sort_d[SORT_PF_SP] = 1'b1;
      end
      if (!prim_pass_i && (sec_judge_i == CHIO_SEC_LOW || sec_judge_i == CHIO_SEC_HIGH)) begin
        sort_d[SORT_PF_SF] = 1'b1;
      end
    end
  end

  // port sequencing: stop wins over start in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= CHIO_IDLE;
    end else begin
      case (state_q)
        CHIO_IDLE, CHIO_DONE: begin
          if (start_evt && !stop_evt) begin
            state_q <= CHIO_MEAS;
          end
        end
        CHIO_MEAS: begin
          if (stop_evt) begin
            state_q <= CHIO_IDLE;
          end else if (meas_done_i) begin
            state_q <= CHIO_DONE;
          end
        end
        default: begin
          state_q <= CHIO_IDLE;
        end
      endcase
    end
  end

  // engine commands, one-cycle pulses
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meas_start_o <= 1'b0;
      meas_abort_o <= 1'b0;
    end else begin
      meas_start_o <= (state_q != CHIO_MEAS) && start_evt && !stop_evt;
      meas_abort_o <= (state_q == CHIO_MEAS) && stop_evt;
    end
  end

  // busy line, low while measuring
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_n_o <= LINE_RST_N;
    end else if (state_q != CHIO_MEAS && start_evt && !stop_evt) begin
      busy_n_o <= 1'b0;
    end else if (state_q == CHIO_MEAS && (stop_evt || meas_done_i)) begin
      busy_n_o <= 1'b1;
    end
  end

  // sort lines and done strobe: set together on completion, released on start
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sort_n_o             <= SORT_RST_N;
      test_done_strobe_n_o <= LINE_RST_N;
    end else if (state_q != CHIO_MEAS && start_evt && !stop_evt) begin
      sort_n_o             <= SORT_RST_N;
      test_done_strobe_n_o <= 1'b1;
    end else if (state_q == CHIO_MEAS && !stop_evt && meas_done_i) begin
      sort_n_o             <= ~sort_d;
      test_done_strobe_n_o <= 1'b0;
    end
  end

  // value to command ports, withheld in no-readout setting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      value_valid_o <= 1'b0;
      value_o       <= '0;
    end else if (state_q == CHIO_MEAS && !stop_evt && meas_done_i && !low_accuracy_no_readout_i) begin
      value_valid_o <= 1'b1;
      value_o       <= meas_value_i;
    end else begin
      value_valid_o <= 1'b0;
    end
  end

  // named steps of a measurement
  sequence start_taken_s;
    state_q != CHIO_MEAS && start_evt && !stop_evt;
  endsequence
  sequence done_taken_s;
    state_q == CHIO_MEAS && !stop_evt && meas_done_i;
  endsequence
  // judgments presented together with a completing measurement
  sequence judged_s;
    done_taken_s ##0 !seq_test_i;
  endsequence
  // step results presented together with a completing sequence test
  sequence seq_judged_s;
    done_taken_s ##0 seq_test_i;
  endsequence
  // a start edge that meets a stop edge
  sequence clash_s;
    start_evt && stop_evt;
  endsequence

  busy_follow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_taken_s |=> !busy_n_o) else $error("busy not asserted after start");
  busy_release_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_taken_s |=> busy_n_o) else $error("busy not released after done");
  start_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_taken_s |=> meas_start_o ##1 !meas_start_o) else $error("start pulse wrong");
  abort_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_q == CHIO_MEAS && stop_evt) |=> meas_abort_o && busy_n_o && state_q == CHIO_IDLE)
    else $error("stop did not abort");
  done_strobe_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_taken_s |=> !test_done_strobe_n_o && busy_n_o) else $error("done strobe missing");
  sort_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_taken_s |=> sort_n_o == SORT_RST_N && test_done_strobe_n_o) else $error("sorts not cleared");
  sort_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_q == CHIO_DONE && !start_evt) |=> $stable(sort_n_o)) else $error("sorts changed while held");
  both_fail_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (!prim_pass_i && (sec_judge_i == CHIO_SEC_LOW || sec_judge_i == CHIO_SEC_HIGH))
    |=> !sort_n_o[SORT_PF_SF]) else $error("both-fail line not driven");
  no_readout_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    low_accuracy_no_readout_i |=> !value_valid_o) else $error("value released in no-readout");
  input_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_n_i |=> !meas_start_o) else $error("start taken on high level");

  // busy mirrors the measuring state at every edge
  busy_state_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    busy_n_o == (state_q != CHIO_MEAS)) else $error("busy does not follow measuring state");

  // sort lines stay released while measuring
  sort_meas_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == CHIO_MEAS |-> sort_n_o == SORT_RST_N) else $error("sorts driven while measuring");

  // done strobe stays released while measuring
  strobe_meas_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == CHIO_MEAS |-> test_done_strobe_n_o) else $error("done strobe low while measuring");

  // done strobe held low after completion
  done_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == CHIO_DONE |-> !test_done_strobe_n_o) else $error("done strobe not held");

  // an abort leaves no results behind
  abort_idle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    meas_abort_o |-> state_q == CHIO_IDLE && sort_n_o == SORT_RST_N && test_done_strobe_n_o)
    else $error("abort left results");

  // no new start while a measurement runs
  start_refused_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == CHIO_MEAS |=> !meas_start_o) else $error("start taken while measuring");

  // no abort when nothing runs
  abort_refused_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q != CHIO_MEAS |=> !meas_abort_o) else $error("abort while idle");

  // stop beats start in the same cycle
  stop_wins_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clash_s |=> !meas_start_o && busy_n_o == $past(busy_n_o) | stop_evt == 1'b0 || busy_n_o)
    else $error("start won over stop");

  // stop while idle changes nothing on busy
  stop_idle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_q != CHIO_MEAS && stop_evt) |=> busy_n_o) else $error("stop while idle raised busy");

  // sequence with every step passing lands on line one
  seq_pass_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_judged_s ##0 (step_fail_i == '0) |=> !sort_n_o[0]) else $error("sequence pass line missing");

  // failed steps map onto lines two..seven
  seq_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_judged_s |=> sort_n_o[SORT_STEP0 +: NUM_STEPS] == ~$past(step_fail_i))
    else $error("step fail lines wrong");

  // primary pass drives its own bin line
  prim_bin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (prim_pass_i && prim_bin_i >= 4'h1 && prim_bin_i <= 4'ha &&
    (sec_judge_i == CHIO_SEC_PASS || sec_judge_i == CHIO_SEC_NONE))
    |=> sort_n_o[$past(prim_bin_i) - 4'h1] == 1'b0) else $error("primary bin line missing");

  // secondary-only binning lands on line one
  sec_only_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (bin_enable_i && prim_limits_off_i && sec_judge_i == CHIO_SEC_PASS)
    |=> !sort_n_o[0]) else $error("secondary-only line missing");

  // primary pass with secondary low
  sec_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (prim_pass_i && sec_judge_i == CHIO_SEC_LOW) |=> !sort_n_o[SORT_SEC_LO])
    else $error("secondary low line missing");

  // primary pass with secondary high
  sec_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (prim_pass_i && sec_judge_i == CHIO_SEC_HIGH) |=> !sort_n_o[SORT_SEC_HI])
    else $error("secondary high line missing");

  // primary fail with secondary pass
  prim_fail_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    judged_s ##0 (!prim_pass_i && sec_judge_i == CHIO_SEC_PASS) |=> !sort_n_o[SORT_PF_SP])
    else $error("primary fail line missing");

  // value released with the result unless withheld
  value_out_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_taken_s ##0 !low_accuracy_no_readout_i |=> value_valid_o && value_o == $past(meas_value_i))
    else $error("value not released");

  // value strobe lasts one cycle
  valid_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    value_valid_o |=> !value_valid_o) else $error("value strobe too long");

  // a stray done pulse outside a measurement leaves results alone
  done_ignored_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_q != CHIO_MEAS && meas_done_i && !start_evt) |=> $stable(sort_n_o) && $stable(test_done_strobe_n_o))
    else $error("results changed outside measurement");
endmodule

/* File: hw/chio_pkg.sv */
package chio_pkg;
  // number of sort lines on the handler port
  localparam int unsigned NUM_SORT      = 14;
  // sequence test step count mapped to lines two..seven
  localparam int unsigned NUM_STEPS     = 6;
  // number of primary bins reported on lines one..ten
  localparam int unsigned NUM_PBINS     = 10;
  // sort line indices (zero based)
  localparam int unsigned SORT_SEC_LO   = 10;
  localparam int unsigned SORT_SEC_HI   = 11;
  localparam int unsigned SORT_PF_SP    = 12;
  localparam int unsigned SORT_PF_SF    = 13;
  localparam int unsigned SORT_STEP0    = 1;
  // released (inactive) level of all active-low outputs after reset
  localparam logic [13:0] SORT_RST_N    = 14'h3fff;
  localparam logic        LINE_RST_N    = 1'b1;
  // width of the primary bin number
  localparam int unsigned BIN_W         = 4;

  // secondary judgment
  typedef enum logic [1:0] {
    CHIO_SEC_PASS,
    CHIO_SEC_LOW,
    CHIO_SEC_HIGH,
    CHIO_SEC_NONE
  } chio_sec_t;

  // handler port sequencing
  typedef enum logic [1:0] {
    CHIO_IDLE,
    CHIO_MEAS,
    CHIO_DONE
  } chio_state_t;
endpackage

/* File: verification/chio_handler_model.sv */
`timescale 1ns/1ps
module chio_handler_model (
  input  wire logic sys_clk_i, // system clock
  input  wire logic go_i,      // request a start pulse
  input  wire logic halt_i,    // request a stop pulse
  output logic      start_n_o, // start line, pulled up when idle
  output logic      stop_n_o   // stop line, pulled up when idle
);
  // lines rest at the pull-up level until a command
  initial begin
    start_n_o = 1'b1;
    stop_n_o  = 1'b1;
  end
  // one-cycle low pulse per command
  always @(posedge sys_clk_i) begin
    start_n_o <= ~go_i;
    stop_n_o  <= ~halt_i;
  end
endmodule

/* File: verification/component_handler_io_tb.sv */
`timescale 1ns/1ps
module component_handler_io_tb;
  import chio_pkg::*;
  logic        clk, rst, go, halt, lnr, done, seq, pp, st_n, sp_n, ms, ma, bz_n, eot_n, vv, eot_q;
  logic        ben, plo; // binning enable, primary limits off
  logic [3:0]  bin;
  chio_sec_t   sec;
  logic [5:0]  sf;
  logic [13:0] so;
  logic [31:0] mv, vo, rs;
  logic [31:0] expq[$]; // expected {valid, sorts}
  int          error_cnt, checked, cyc;
  // xorshift source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected sort lines from the judgments
  function automatic logic [13:0] sort_exp();
    logic [13:0] a;
    a = 14'h0000;
    if (seq) a = {7'h00, sf, sf == 6'h00};
    else if (pp && (sec == CHIO_SEC_PASS || sec == CHIO_SEC_NONE)) a[bin - 4'h1] = 1'b1;
    else if (pp) a[sec == CHIO_SEC_LOW ? 10 : 11] = 1'b1;
    else a[sec == CHIO_SEC_PASS ? 12 : 13] = 1'b1;
    if (!seq && ben && plo && sec == CHIO_SEC_PASS) a[0] = 1'b1;
    return ~a;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one measurement, optionally stopped
  task automatic measure(input bit abort);
    @(posedge clk);
    rs = xs(rs);
    seq <= rs[0];
    pp  <= rs[1];
    lnr <= rs[2];
    sf  <= rs[8:3];
    bin <= 4'(rs[12:9] % 10 + 1);
    sec <= chio_sec_t'(rs[1] ? rs[14:13] : 2'(rs[14:13] % 3));
    mv  <= rs;
    ben <= rs[15];
    plo <= rs[16];
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 4 && ms !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check({ms, bz_n, eot_n, so}, {3'b101, 14'h3fff});
    @(posedge clk);
    done <= ~abort;
    halt <= abort;
    expq.push_back(abort ? 32'h3fff : {~lnr, sort_exp()});
    @(posedge clk);
    done <= 1'b0;
    halt <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({bz_n, eot_n}, {1'b1, abort});
  endtask
  // result watcher
  always @(posedge clk) begin
    #1;
    if ((eot_q && !eot_n) || ma) check({vv, so}, expq.pop_front());
    if (vv) check(vo, mv);
    eot_q = eot_n;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, go, halt, lnr, done, seq, pp, bin, sf, mv, eot_q} = {7'h41, 4'h1, 6'h00, 32'h0, 1'b1};
    sec = CHIO_SEC_PASS;
    ben = 1'b0;
    plo = 1'b0;
    rs  = 32'ha66ea186;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 60; i++) measure(i % 5 == 4);
    report_and_stop();
  end
  chio_handler_model i_hdl (.sys_clk_i(clk), .go_i(go), .halt_i(halt), .start_n_o(st_n), .stop_n_o(sp_n));
  chio_handler_io i_dut (
    .sys_clk_i(clk), .rst_i(rst), .start_n_i(st_n), .stop_n_i(sp_n), .low_accuracy_no_readout_i(lnr),
    .meas_done_i(done), .seq_test_i(seq), .prim_pass_i(pp), .prim_bin_i(bin), .bin_enable_i(ben),
    .prim_limits_off_i(plo), .sec_judge_i(sec), .step_fail_i(sf), .meas_value_i(mv),
    .meas_start_o(ms), .meas_abort_o(ma), .busy_n_o(bz_n), .test_done_strobe_n_o(eot_n),
    .sort_n_o(so), .value_valid_o(vv), .value_o(vo));
endmodule
